// >>> verilog/acs_defs.vh
// Constants for the converter sequencer
// What this block does
// - Writing start launches one conversion; bit reads high until done, then clears unless free-run is selected.
// - Channel changed mid-conversion applies only after the running conversion ends.
// - Free-run set by free_run_select; first conversion still needs a start write.
// - Free-run conversions continue regardless of the done flag state.
// - Prescaler counts while enabled, held in reset whenever enable is low.
// - Single-ended conversion starts at next rising prescaled clock edge after start.
// - Normal single-ended conversion lasts 13 converter clock cycles.
// - First conversion after enable lasts 25 converter clock cycles.
// - Sample point at 1.5 cycles normally, 13.5 cycles on first conversion.
// - Completion stores result, sets done flag, clears start in single mode.
// - Free-run restarts immediately at completion, start bit stays high.
// - Differential conversions align to half-rate clock for a fixed sample edge.
// - User differential start takes 13 cycles if half clock low, 14 if high.
// - Automatic differential restarts in free-run take 14 cycles.
// - Selections buffered; active selection tracks buffer until conversion starts.
// - Active selection tracks buffer again in last cycle before done flag.
// - Free-run channel change mid-run yields one more result from old channel.
// - Low byte read blocks result updates until high byte read; flag still sets.
// - Selections take no effect until converter_enable is set.
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH
`define ACS_NORMAL_CYCLES 5'd13
`define ACS_DIFF_SYNC_CYCLES 5'd14
`define ACS_FIRST_CYCLES 5'd25
`define ACS_SAMPLE_NORMAL 5'd1
`define ACS_SAMPLE_DIFF_SYNC 5'd2
`define ACS_SAMPLE_FIRST 5'd13
`define ACS_PSC_WIDTH 7
`define ACS_RESULT_RESET 10'h000
`define ACS_CHAN_RESET 5'h00
`define ACS_REF_RESET 2'h0
`endif

// >>> verilog/acs_prescaler.v
// Converter clock prescaler producing rising and falling edge strobes
`timescale 1ns/1ps
`include "acs_defs.vh"
module acs_prescaler (
    input wire clk_in,
    input wire reset_n_in,
    input wire enable_in,
    input wire [2:0] div_sel_in,
    output reg rise_out,
    output reg fall_out
);
    reg [`ACS_PSC_WIDTH-1:0] count_r;
    reg [`ACS_PSC_WIDTH-1:0] half_w;

    // Ratio set: 2^(sel), sel 0 treated as 2
    always @* begin
        case (div_sel_in)
            3'h0: half_w = 7'h01;
            3'h1: half_w = 7'h01;
            3'h2: half_w = 7'h02;
            3'h3: half_w = 7'h04;
            3'h4: half_w = 7'h08;
            3'h5: half_w = 7'h10;
            3'h6: half_w = 7'h20;
            default: half_w = 7'h40;
        endcase
    end

    always @(posedge clk_in) begin
        if (!reset_n_in || !enable_in) begin
            count_r <= 7'h00;
            rise_out <= 1'b0;
            fall_out <= 1'b0;
        end else begin
            count_r <= (count_r == ((half_w << 1) - 7'h01)) ? 7'h00 : count_r + 7'h01;
            rise_out <= (count_r == ((half_w << 1) - 7'h01));
            fall_out <= (count_r == (half_w - 7'h01));
        end
    end
endmodule // acs_prescaler

// >>> verilog/acs_select_buffer.v
// Buffered channel and reference selection with freeze during conversion
`timescale 1ns/1ps
`include "acs_defs.vh"
module acs_select_buffer #(
    parameter CHAN_W = 5
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire enable_in,
    input wire track_in,
    input wire [CHAN_W-1:0] chan_buf_in,
    input wire [1:0] ref_buf_in,
    output reg [CHAN_W-1:0] chan_out,
    output reg [1:0] ref_out
);
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            chan_out <= `ACS_CHAN_RESET;
            ref_out <= `ACS_REF_RESET;
        end else if (enable_in && track_in) begin
            chan_out <= chan_buf_in;
            ref_out <= ref_buf_in;
        end
    end
endmodule // acs_select_buffer

// >>> verilog/acs_sequencer.v
// Conversion sequencer: start, free-run, timing, sample point and result handling
`timescale 1ns/1ps
`include "acs_defs.vh"
module acs_sequencer #(
    parameter CHAN_W = 5
) (
    input wire CORE_CLK_IN,
    input wire RESET_N_IN,
    input wire CONVERTER_ENABLE_IN,
    input wire START_CONVERSION_WRITE_IN,
    input wire FREE_RUN_SELECT_IN,
    input wire [2:0] CLOCK_DIVIDER_SELECT_IN,
    input wire DONE_FLAG_CLEAR_IN,
    input wire [CHAN_W-1:0] CHANNEL_SELECT_IN,
    input wire [1:0] REFERENCE_SELECT_IN,
    input wire DIFFERENTIAL_IN,
    input wire [9:0] SAR_RESULT_IN,
    input wire RESULT_LOW_READ_IN,
    input wire RESULT_HIGH_READ_IN,
    output reg START_CONVERSION_OUT,
    output reg CONVERSION_DONE_FLAG_OUT,
    output reg CONVERSION_DONE_PULSE_OUT,
    output reg SAMPLE_HOLD_OUT,
    output reg BUSY_OUT,
    output reg HALF_RATE_SYNC_CLOCK_OUT,
    output reg [9:0] RESULT_OUT,
    output reg [CHAN_W-1:0] ACTIVE_CHANNEL_OUT,
    output reg [1:0] ACTIVE_REFERENCE_OUT
);
    localparam ST_IDLE = 2'd0;
    localparam ST_ARMED = 2'd1;
    localparam ST_CONV = 2'd2;

    reg [1:0] state_r;
    reg [4:0] cyc_r;
    reg [4:0] len_r;
    reg [4:0] sample_r;
    reg first_r;
    reg lock_r;
    reg track_r;
    reg sh_pend_r;
    wire psc_rise;
    wire psc_fall;
    wire [CHAN_W-1:0] sel_chan;
    wire [1:0] sel_ref;
    wire last_cycle;
    reg [4:0] len_nxt;
    reg [4:0] sample_nxt;
    // Set by a low-byte read so the pair belongs to one conversion, except when that read falls in the cycle a conversion completes
    reg res_hold_r;

    acs_prescaler u_psc (
        .clk_in(CORE_CLK_IN),
        .reset_n_in(RESET_N_IN),
        .enable_in(CONVERTER_ENABLE_IN),
        .div_sel_in(CLOCK_DIVIDER_SELECT_IN),
        .rise_out(psc_rise),
        .fall_out(psc_fall)
    );

    acs_select_buffer #(.CHAN_W(CHAN_W)) u_sel (
        .clk_in(CORE_CLK_IN),
        .reset_n_in(RESET_N_IN),
        .enable_in(CONVERTER_ENABLE_IN),
        .track_in(track_r),
        .chan_buf_in(CHANNEL_SELECT_IN),
        .ref_buf_in(REFERENCE_SELECT_IN),
        .chan_out(sel_chan),
        .ref_out(sel_ref)
    );

    assign last_cycle = (state_r == ST_CONV) && (cyc_r == len_r - 5'd1);

    // Length and sample point of a conversion about to start
    always @* begin
        len_nxt = `ACS_NORMAL_CYCLES;
        sample_nxt = `ACS_SAMPLE_NORMAL;
        if (first_r) begin
            len_nxt = `ACS_FIRST_CYCLES;
            sample_nxt = `ACS_SAMPLE_FIRST;
        end else if (DIFFERENTIAL_IN && HALF_RATE_SYNC_CLOCK_OUT) begin
            len_nxt = `ACS_DIFF_SYNC_CYCLES;
            sample_nxt = `ACS_SAMPLE_DIFF_SYNC;
        end
    end

    // Selection tracks unless locked; also tracks in the final cycle
    always @* begin
        track_r = !lock_r || (last_cycle && psc_rise);
    end

    always @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
            state_r <= ST_IDLE;
            cyc_r <= 5'd0;
            len_r <= `ACS_NORMAL_CYCLES;
            sample_r <= `ACS_SAMPLE_NORMAL;
            first_r <= 1'b1;
            lock_r <= 1'b0;
            sh_pend_r <= 1'b0;
            START_CONVERSION_OUT <= 1'b0;
            CONVERSION_DONE_FLAG_OUT <= 1'b0;
            CONVERSION_DONE_PULSE_OUT <= 1'b0;
            SAMPLE_HOLD_OUT <= 1'b0;
            BUSY_OUT <= 1'b0;
            HALF_RATE_SYNC_CLOCK_OUT <= 1'b0;
            RESULT_OUT <= `ACS_RESULT_RESET;
            ACTIVE_CHANNEL_OUT <= `ACS_CHAN_RESET;
            ACTIVE_REFERENCE_OUT <= `ACS_REF_RESET;
        end else begin
            CONVERSION_DONE_PULSE_OUT <= 1'b0;
            SAMPLE_HOLD_OUT <= 1'b0;
            ACTIVE_CHANNEL_OUT <= sel_chan;
            ACTIVE_REFERENCE_OUT <= sel_ref;
            if (DONE_FLAG_CLEAR_IN) begin
                CONVERSION_DONE_FLAG_OUT <= 1'b0;
            end
            if (!CONVERTER_ENABLE_IN) begin
                // Disabling aborts and re-arms the long first conversion
                state_r <= ST_IDLE;
                first_r <= 1'b1;
                lock_r <= 1'b0;
                HALF_RATE_SYNC_CLOCK_OUT <= 1'b0;
                START_CONVERSION_OUT <= 1'b0;
                BUSY_OUT <= 1'b0;
            end else begin
                if (psc_rise) begin
                    HALF_RATE_SYNC_CLOCK_OUT <= !HALF_RATE_SYNC_CLOCK_OUT;
                end
                if (sh_pend_r && psc_fall) begin
                    SAMPLE_HOLD_OUT <= 1'b1;
                    sh_pend_r <= 1'b0;
                end
                case (state_r)
                    ST_IDLE: begin
                        if (START_CONVERSION_WRITE_IN) begin
                            START_CONVERSION_OUT <= 1'b1;
                            state_r <= ST_ARMED;
                        end
                    end
                    ST_ARMED: begin
                        if (psc_rise) begin
                            state_r <= ST_CONV;
                            cyc_r <= 5'd0;
                            len_r <= len_nxt;
                            sample_r <= sample_nxt;
                            lock_r <= 1'b1;
                            BUSY_OUT <= 1'b1;
                            sh_pend_r <= (sample_nxt == 5'd0);
                        end
                    end
                    ST_CONV: begin
                        if (psc_rise) begin
                            cyc_r <= cyc_r + 5'd1;
                            if (cyc_r + 5'd1 == sample_r) begin
                                sh_pend_r <= 1'b1;
                            end
                            if (last_cycle) begin
                                first_r <= 1'b0;
                                lock_r <= 1'b0;
                                CONVERSION_DONE_FLAG_OUT <= 1'b1;
                                CONVERSION_DONE_PULSE_OUT <= 1'b1;
                                if (!res_hold_r) begin
                                    RESULT_OUT <= SAR_RESULT_IN;
                                end
                                if (FREE_RUN_SELECT_IN) begin
                                    // Restart now, ignoring flag state; selection
                                    // latched at this edge is used next time
                                    state_r <= ST_CONV;
                                    cyc_r <= 5'd0;
                                    len_r <= DIFFERENTIAL_IN ? `ACS_DIFF_SYNC_CYCLES
                                                             : `ACS_NORMAL_CYCLES;
                                    sample_r <= DIFFERENTIAL_IN ? `ACS_SAMPLE_DIFF_SYNC
                                                                : `ACS_SAMPLE_NORMAL;
                                    lock_r <= 1'b1;
                                end else begin
                                    state_r <= ST_IDLE;
                                    START_CONVERSION_OUT <= 1'b0;
                                    BUSY_OUT <= 1'b0;
                                end
                            end
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // Low byte read holds result until the high byte is read
    always @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
            res_hold_r <= 1'b0;
        end else if (RESULT_HIGH_READ_IN) begin
            res_hold_r <= 1'b0;
        end else if (RESULT_LOW_READ_IN) begin
            res_hold_r <= 1'b1;
        end
    end
endmodule // acs_sequencer

// >>> testbench/acs_props.sv
// Port-level assertions for the conversion sequencer
`timescale 1ns/1ps
module acs_props #(
    parameter CHAN_W = 5
) (
    input wire CORE_CLK_IN,
    input wire RESET_N_IN,
    input wire CONVERTER_ENABLE_IN,
    input wire START_CONVERSION_WRITE_IN,
    input wire FREE_RUN_SELECT_IN,
    input wire RESULT_LOW_READ_IN,
    input wire RESULT_HIGH_READ_IN,
    input wire START_CONVERSION_OUT,
    input wire CONVERSION_DONE_FLAG_OUT,
    input wire CONVERSION_DONE_PULSE_OUT,
    input wire BUSY_OUT,
    input wire [9:0] RESULT_OUT,
    input wire [CHAN_W-1:0] ACTIVE_CHANNEL_OUT
);
default clocking @(posedge CORE_CLK_IN); endclocking
default disable iff (!RESET_N_IN);
// Set by a low-byte read, dropped by the high-byte read
reg lock_r;
always @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN || RESULT_HIGH_READ_IN)
        lock_r <= 1'b0;
    else if (RESULT_LOW_READ_IN)
        lock_r <= 1'b1;
end
property p_flag; CONVERSION_DONE_PULSE_OUT |-> CONVERSION_DONE_FLAG_OUT; endproperty
a_flag: assert property (p_flag) else $error("done without flag");
property p_busy; BUSY_OUT |-> START_CONVERSION_OUT; endproperty
a_busy: assert property (p_busy) else $error("busy with start low");
property p_clr; CONVERSION_DONE_PULSE_OUT && !FREE_RUN_SELECT_IN |-> !START_CONVERSION_OUT;
endproperty
a_clr: assert property (p_clr) else $error("start kept after single");
property p_keep; CONVERSION_DONE_PULSE_OUT && FREE_RUN_SELECT_IN
    |-> START_CONVERSION_OUT ##[1:4] BUSY_OUT; endproperty
a_keep: assert property (p_keep) else $error("free run stopped");
property p_idle; (!CONVERTER_ENABLE_IN [*2]) |-> !BUSY_OUT; endproperty
a_idle: assert property (p_idle) else $error("busy while disabled");
property p_go; START_CONVERSION_WRITE_IN && CONVERTER_ENABLE_IN && !BUSY_OUT
    && !START_CONVERSION_OUT |-> ##[1:300] BUSY_OUT; endproperty
a_go: assert property (p_go) else $error("start not taken");
property p_frz; $rose(BUSY_OUT) |-> ##2 $stable(ACTIVE_CHANNEL_OUT) [*8]; endproperty
a_frz: assert property (p_frz) else $error("channel moved mid conversion");
property p_lock; lock_r && !RESULT_HIGH_READ_IN |=> $stable(RESULT_OUT); endproperty
a_lock: assert property (p_lock) else $error("result changed while locked");
endmodule // acs_props
bind acs_sequencer acs_props #(.CHAN_W(CHAN_W)) u_props (.CORE_CLK_IN(CORE_CLK_IN),
    .RESET_N_IN(RESET_N_IN), .CONVERTER_ENABLE_IN(CONVERTER_ENABLE_IN),
    .START_CONVERSION_WRITE_IN(START_CONVERSION_WRITE_IN),
    .FREE_RUN_SELECT_IN(FREE_RUN_SELECT_IN), .RESULT_LOW_READ_IN(RESULT_LOW_READ_IN),
    .RESULT_HIGH_READ_IN(RESULT_HIGH_READ_IN), .START_CONVERSION_OUT(START_CONVERSION_OUT),
    .CONVERSION_DONE_FLAG_OUT(CONVERSION_DONE_FLAG_OUT),
    .CONVERSION_DONE_PULSE_OUT(CONVERSION_DONE_PULSE_OUT), .BUSY_OUT(BUSY_OUT),
    .RESULT_OUT(RESULT_OUT), .ACTIVE_CHANNEL_OUT(ACTIVE_CHANNEL_OUT));

// >>> testbench/testbench.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module testbench;
reg clk = 0, rst_n = 0, en = 0, sw = 0, fr = 0, clr = 0, diff = 0, lo = 0, hi = 0, h = 0;
reg [9:0] sar = 10'h2a5;
reg [4:0] chan = 5'h00;
reg [1:0] rs = 2'h0;
wire so, flag, pulse, busy, half;
wire [9:0] res;
wire [4:0] ach;
wire [1:0] aref;
int error_cnt = 0, n_checks = 0, n;
// Divide by two keeps every conversion short
acs_sequencer dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .CONVERTER_ENABLE_IN(en),
    .START_CONVERSION_WRITE_IN(sw), .FREE_RUN_SELECT_IN(fr), .CLOCK_DIVIDER_SELECT_IN(3'h1),
    .DONE_FLAG_CLEAR_IN(clr), .CHANNEL_SELECT_IN(chan), .REFERENCE_SELECT_IN(rs),
    .DIFFERENTIAL_IN(diff), .SAR_RESULT_IN(sar), .RESULT_LOW_READ_IN(lo),
    .RESULT_HIGH_READ_IN(hi), .START_CONVERSION_OUT(so), .CONVERSION_DONE_FLAG_OUT(flag),
    .CONVERSION_DONE_PULSE_OUT(pulse), .SAMPLE_HOLD_OUT(), .BUSY_OUT(busy),
    .HALF_RATE_SYNC_CLOCK_OUT(half), .RESULT_OUT(res), .ACTIVE_CHANNEL_OUT(ach),
    .ACTIVE_REFERENCE_OUT(aref));
task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
        error_cnt++;
        $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
endtask
task tick;
    @(posedge clk);
    #1;
endtask
task go;
    @(posedge clk);
    sw <= 1'b1;
    #1 h = half;
    @(posedge clk);
    sw <= 1'b0;
    #1;
endtask
// Length in converter cycles, one system cycle of slack for strobe phase
task conv(input int c, input bit wb);
    n = 0;
    while (wb && busy !== 1'b1 && n < 300) begin
        tick();
        n++;
    end
    n = 0;
    do begin
        tick();
        n++;
    end while (pulse !== 1'b1 && n < 300);
    if (c > 0) check("length", n >= 2 * c - 1 && n <= 2 * c + 1, 1);
endtask
task t_single;
    go();
    check("start", so, 1);
    conv(25, 1);
    check("result", res, 10'h2a5);
    check("flag", flag, 1);
    check("start clr", so, 0);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    go();
    conv(13, 1);
    $display("single test done");
endtask
task t_diff;
    @(posedge clk);
    diff <= 1'b1;
    for (int i = 0; i < 4; i++) begin
        repeat (i) tick();
        go();
        while (busy !== 1'b1) tick();
        // Half-rate level just before the starting edge decides the length
        h = !half;
        conv(13 + h, 0);
    end
    $display("differential test done");
endtask
task t_free;
    @(posedge clk);
    fr <= 1'b1;
    go();
    conv(0, 1);
    for (int i = 0; i < 2; i++) begin
        check("free start", so, 1);
        conv(14, 0);
    end
    @(posedge clk);
    en <= 1'b0;
    fr <= 1'b0;
    diff <= 1'b0;
    repeat (3) tick();
    check("stopped", busy, 0);
    @(posedge clk);
    en <= 1'b1;
    $display("free-run test done");
endtask
task t_sel;
    @(posedge clk);
    chan <= 5'h03;
    rs <= 2'h1;
    repeat (3) tick();
    check("track", {aref, ach}, {2'h1, 5'h03});
    go();
    repeat (4) @(posedge clk);
    chan <= 5'h07;
    rs <= 2'h2;
    repeat (20) tick();
    check("frozen", {aref, ach}, {2'h1, 5'h03});
    conv(0, 0);
    repeat (2) tick();
    check("resumed", {aref, ach}, {2'h2, 5'h07});
    $display("selection test done");
endtask
task t_lock;
    @(posedge clk);
    lo <= 1'b1;
    sar <= 10'h0aa;
    @(posedge clk);
    lo <= 1'b0;
    go();
    conv(0, 1);
    check("lost", res, 10'h2a5);
    check("pulse", pulse, 1);
    @(posedge clk);
    hi <= 1'b1;
    @(posedge clk);
    hi <= 1'b0;
    go();
    conv(13, 1);
    check("unlocked", res, 10'h0aa);
    @(posedge clk);
    en <= 1'b0;
    go();
    repeat (40) tick();
    check("refused", busy, 0);
    $display("lock and disable test done");
endtask
task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
initial begin
    forever #20 clk = ~clk;
end
initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
end
initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    en <= 1'b1;
    t_single();
    t_diff();
    t_free();
    t_sel();
    t_lock();
    print_verdict();
end
endmodule // testbench
